// File: rtl/vfd_decoder_map.svh
`ifndef VFD_DECODER_MAP_SVH
`define VFD_DECODER_MAP_SVH

// Clock
`define VFD_CLK_PERIOD_NS    20

// Scan timing, figures in ns apart from the grid count
`define VFD_LIT_TIME_NS      200000
`define VFD_BLANK_TIME_NS    10000
`define VFD_BLINK_HALF_NS    500000000
`define VFD_GRID_COUNT       20

// Memory geometry
`define VFD_DRAM_AW          7
`define VFD_GRAM_AW          6
`define VFD_LINE_LEN         7'h28
`define VFD_ROW_CURSOR       3'h7

// Reset and fill values
`define VFD_SPACE_CODE       8'h20
`define VFD_ADDR_ZERO        7'h00
`define VFD_RST_STEP_DIR     1'b1
`define VFD_RST_SHIFT_WR     1'b0
`define VFD_RST_DISP_EN      1'b0
`define VFD_RST_CURS_EN      1'b0
`define VFD_RST_BLINK_EN     1'b0
`define VFD_RST_BUS_WIDTH    1'b1
`define VFD_RST_LINES        1'b1
`define VFD_RST_LUMA         2'h0

// Command field positions
`define VFD_BIT_ENTRY_DIR    1
`define VFD_BIT_ENTRY_SHIFT  0
`define VFD_BIT_DISP_EN      2
`define VFD_BIT_CURS_EN      1
`define VFD_BIT_BLINK_EN     0
`define VFD_BIT_SHIFT_TGT    3
`define VFD_BIT_SHIFT_DIR    2
`define VFD_BIT_BUS_WIDTH    4
`define VFD_BIT_LINES        3
`define VFD_BUSY_BIT         7

`endif

// File: rtl/vfd_decoder_pkg.sv
package vfd_decoder_pkg;

  typedef enum logic [0:0]
  {
    ST_FILL = 1'b0,
    ST_IDLE = 1'b1
  } dec_state_t;

  typedef enum logic [0:0]
  {
    TGT_DISPLAY = 1'b0,
    TGT_GLYPH   = 1'b1
  } ram_target_t;

endpackage

// File: rtl/vfd_instruction_decoder.sv
`timescale 1ns/10ps
`include "vfd_decoder_map.svh"

module vfd_instruction_decoder
  import vfd_decoder_pkg::*;
#(
  parameter int LIT_CYCLES   = `VFD_LIT_TIME_NS / `VFD_CLK_PERIOD_NS,
  parameter int BLINK_CYCLES = `VFD_BLINK_HALF_NS / `VFD_CLK_PERIOD_NS
)
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       host_valid,
  input  wire logic       host_write,
  input  wire logic       cmd_data_sel,
  input  wire logic [7:0] host_wdata,
  output logic            host_ready,
  output logic [7:0]      host_rdata,
  output logic            host_rvalid,
  input  wire logic [6:0] scan_addr,
  input  wire logic [2:0] scan_row,
  output logic [7:0]      scan_code,
  output logic            scan_blank,
  output logic            scan_all_on,
  output logic            scan_cursor,
  output logic [4:0]      grid_index,
  output logic            seg_enable,
  output logic [6:0]      address_counter,
  output logic            glyph_selected,
  output logic [5:0]      display_shift,
  output logic            step_direction,
  output logic            shift_on_write,
  output logic            display_enable,
  output logic            cursor_enable,
  output logic            blink_enable,
  output logic            bus_width_sel,
  output logic            line_count_sel,
  output logic [1:0]      luma_level
);

  localparam int BLANK_CYCLES = `VFD_BLANK_TIME_NS / `VFD_CLK_PERIOD_NS;
  localparam int SLOT_CYCLES  = LIT_CYCLES + BLANK_CYCLES;
  localparam int LIT_QUARTER  = LIT_CYCLES / 4;
  localparam logic [6:0] LINE_LEN = `VFD_LINE_LEN;

  logic [7:0]  dram [0:(1 << `VFD_DRAM_AW) - 1];
  logic [7:0]  gram [0:(1 << `VFD_GRAM_AW) - 1];

  dec_state_t  state_q;
  ram_target_t target_q;
  logic [6:0]  fill_addr_q;
  logic [6:0]  ac_q;
  logic [5:0]  shift_q;
  logic        step_dir_q;
  logic        shift_wr_q;
  logic        disp_en_q;
  logic        curs_en_q;
  logic        blink_en_q;
  logic        bus_w_q;
  logic        lines_q;
  logic [1:0]  luma_q;
  logic [31:0] blink_cnt_q;
  logic        blink_phase_q;
  logic [31:0] slot_cnt_q;
  logic [4:0]  grid_q;
  logic [7:0]  rdata_q;
  logic        rvalid_q;
  logic [7:0]  scan_code_q;
  logic        scan_blank_q;
  logic        scan_all_q;
  logic        scan_curs_q;
  logic        seg_en_q;

  logic        take;
  logic        cmd_wr;
  logic        data_wr;
  logic        data_rd;
  logic        cmd_rd;
  logic        is_clear;
  logic [6:0]  ac_step;
  logic [5:0]  shift_inc;
  logic [5:0]  shift_dec;
  logic [6:0]  col_sum;
  logic [6:0]  col_eff;
  logic [6:0]  scan_eff;
  logic        at_cursor;
  logic [31:0] lit_scaled;

  assign host_ready = (state_q == ST_IDLE);
  assign take       = host_valid && host_ready;
  assign cmd_wr     = take && host_write && !cmd_data_sel;
  assign cmd_rd     = take && !host_write && !cmd_data_sel;
  assign data_wr    = take && host_write && cmd_data_sel;
  assign data_rd    = take && !host_write && cmd_data_sel;
  assign is_clear   = cmd_wr && (host_wdata == 8'h01);

  always_comb
  begin
    if (target_q == TGT_GLYPH)
    begin
      ac_step = step_dir_q ? {1'b0, ac_q[5:0] + 6'h01} : {1'b0, ac_q[5:0] - 6'h01};
    end
    else
    begin
      ac_step = step_dir_q ? (ac_q + 7'h01) : (ac_q - 7'h01);
    end
  end

  // Shift offset wraps on the 40-character line
  assign shift_inc = (shift_q == 6'(LINE_LEN - 7'h01)) ? 6'h00 : shift_q + 6'h01;
  assign shift_dec = (shift_q == 6'h00) ? 6'(LINE_LEN - 7'h01) : shift_q - 6'h01;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q     <= ST_FILL;
      fill_addr_q <= `VFD_ADDR_ZERO;
    end
    else if (state_q == ST_FILL)
    begin
      fill_addr_q <= fill_addr_q + 7'h01;
      if (fill_addr_q == 7'h7F)
      begin
        state_q <= ST_IDLE;
      end
    end
    else if (is_clear)
    begin
      state_q     <= ST_FILL;
      fill_addr_q <= `VFD_ADDR_ZERO;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (state_q == ST_FILL)
    begin
      dram[fill_addr_q] <= `VFD_SPACE_CODE;
    end
    else if (data_wr && (target_q == TGT_DISPLAY))
    begin
      dram[ac_q] <= host_wdata;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (data_wr && (target_q == TGT_GLYPH))
    begin
      gram[ac_q[5:0]] <= host_wdata;
    end
  end

  // Address counter and RAM target
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ac_q     <= `VFD_ADDR_ZERO;
      target_q <= TGT_DISPLAY;
    end
    else if (cmd_wr)
    begin
      casez (host_wdata)
        8'b0000_0001,
        8'b0000_001?:
        begin
          ac_q     <= `VFD_ADDR_ZERO;
          target_q <= TGT_DISPLAY;
        end
        8'b0001_????:
        begin
          if (target_q == TGT_GLYPH)
          begin
            ac_q <= host_wdata[`VFD_BIT_SHIFT_DIR] ? {1'b0, ac_q[5:0] + 6'h01}
                                                   : {1'b0, ac_q[5:0] - 6'h01};
          end
          else
          begin
            ac_q <= host_wdata[`VFD_BIT_SHIFT_DIR] ? ac_q + 7'h01 : ac_q - 7'h01;
          end
        end
        8'b01??_????:
        begin
          ac_q     <= {1'b0, host_wdata[5:0]};
          target_q <= TGT_GLYPH;
        end
        8'b1???_????:
        begin
          ac_q     <= host_wdata[6:0];
          target_q <= TGT_DISPLAY;
        end
        default:
        begin
          ac_q <= ac_q;
        end
      endcase
    end
    else if (data_wr || data_rd)
    begin
      // With shift-on-write, display RAM writes move the display instead of the cursor
      if (!(data_wr && shift_wr_q && (target_q == TGT_DISPLAY)))
      begin
        ac_q <= ac_step;
      end
    end
  end

  // Display shift offset
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      shift_q <= 6'h00;
    end
    else if (cmd_wr && (host_wdata[7:1] == 7'h00 || host_wdata[7:1] == 7'h01)
             && host_wdata != 8'h00)
    begin
      shift_q <= 6'h00;
    end
    else if (cmd_wr && host_wdata[7:4] == 4'h1 && host_wdata[`VFD_BIT_SHIFT_TGT])
    begin
      shift_q <= host_wdata[`VFD_BIT_SHIFT_DIR] ? shift_dec : shift_inc;
    end
    else if (data_wr && shift_wr_q && (target_q == TGT_DISPLAY))
    begin
      shift_q <= step_dir_q ? shift_inc : shift_dec;
    end
  end

  // Mode settings
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      step_dir_q <= `VFD_RST_STEP_DIR;
      shift_wr_q <= `VFD_RST_SHIFT_WR;
      disp_en_q  <= `VFD_RST_DISP_EN;
      curs_en_q  <= `VFD_RST_CURS_EN;
      blink_en_q <= `VFD_RST_BLINK_EN;
      bus_w_q    <= `VFD_RST_BUS_WIDTH;
      lines_q    <= `VFD_RST_LINES;
      luma_q     <= `VFD_RST_LUMA;
    end
    else if (cmd_wr)
    begin
      casez (host_wdata)
        8'b0000_0001:
        begin
          step_dir_q <= 1'b1;
        end
        8'b0000_01??:
        begin
          step_dir_q <= host_wdata[`VFD_BIT_ENTRY_DIR];
          shift_wr_q <= host_wdata[`VFD_BIT_ENTRY_SHIFT];
        end
        8'b0000_1???:
        begin
          disp_en_q  <= host_wdata[`VFD_BIT_DISP_EN];
          curs_en_q  <= host_wdata[`VFD_BIT_CURS_EN];
          blink_en_q <= host_wdata[`VFD_BIT_BLINK_EN];
        end
        8'b001?_????:
        begin
          bus_w_q <= host_wdata[`VFD_BIT_BUS_WIDTH];
          lines_q <= host_wdata[`VFD_BIT_LINES];
          luma_q  <= host_wdata[1:0];
        end
        default:
        begin
          luma_q <= luma_q;
        end
      endcase
    end
  end

  // Host read data
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= cmd_rd || data_rd;
      if (cmd_rd)
      begin
        rdata_q <= {1'b0, ac_q};
      end
      else if (data_rd)
      begin
        rdata_q <= (target_q == TGT_GLYPH) ? gram[ac_q[5:0]] : dram[ac_q];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      blink_cnt_q   <= 32'h0000_0000;
      blink_phase_q <= 1'b0;
    end
    else if (blink_cnt_q == 32'(BLINK_CYCLES - 1))
    begin
      blink_cnt_q   <= 32'h0000_0000;
      blink_phase_q <= !blink_phase_q;
    end
    else
    begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  assign lit_scaled = 32'(LIT_QUARTER) * {29'h0, 3'h4 - {1'b0, luma_q}};

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      slot_cnt_q <= 32'h0000_0000;
      grid_q     <= 5'h00;
      seg_en_q   <= 1'b0;
    end
    else
    begin
      seg_en_q <= disp_en_q && (slot_cnt_q < lit_scaled);
      if (slot_cnt_q == 32'(SLOT_CYCLES - 1))
      begin
        slot_cnt_q <= 32'h0000_0000;
        grid_q     <= (grid_q == 5'(`VFD_GRID_COUNT - 1)) ? 5'h00 : grid_q + 5'h01;
      end
      else
      begin
        slot_cnt_q <= slot_cnt_q + 32'h0000_0001;
      end
    end
  end

  // Scan position maps through the shift offset within its line
  assign col_sum   = {1'b0, scan_addr[5:0]} + {1'b0, shift_q};
  assign col_eff   = (col_sum >= LINE_LEN) ? col_sum - LINE_LEN : col_sum;
  assign scan_eff  = {scan_addr[6], col_eff[5:0]};
  assign at_cursor = (target_q == TGT_DISPLAY) && (scan_eff == ac_q);

  // Cursor overlay stays off while the counter points into glyph RAM
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      scan_code_q  <= `VFD_SPACE_CODE;
      scan_blank_q <= 1'b1;
      scan_all_q   <= 1'b0;
      scan_curs_q  <= 1'b0;
    end
    else
    begin
      scan_code_q  <= dram[scan_eff];
      scan_blank_q <= !disp_en_q;
      scan_all_q   <= disp_en_q && blink_en_q && blink_phase_q && at_cursor;
      scan_curs_q  <= disp_en_q && curs_en_q && at_cursor && (scan_row == `VFD_ROW_CURSOR);
    end
  end

  assign host_rdata      = rdata_q;
  assign host_rvalid     = rvalid_q;
  assign scan_code       = scan_code_q;
  assign scan_blank      = scan_blank_q;
  assign scan_all_on     = scan_all_q;
  assign scan_cursor     = scan_curs_q;
  assign grid_index      = grid_q;
  assign seg_enable      = seg_en_q;
  assign address_counter = ac_q;
  assign glyph_selected  = (target_q == TGT_GLYPH);
  assign display_shift   = shift_q;
  assign step_direction  = step_dir_q;
  assign shift_on_write  = shift_wr_q;
  assign display_enable  = disp_en_q;
  assign cursor_enable   = curs_en_q;
  assign blink_enable    = blink_en_q;
  assign bus_width_sel   = bus_w_q;
  assign line_count_sel  = lines_q;
  assign luma_level      = luma_q;

endmodule

// File: testbench/vfd_decoder_chk.sv
`timescale 1ns/10ps
module vfd_decoder_chk
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       host_valid,
  input wire logic       host_write,
  input wire logic       cmd_data_sel,
  input wire logic [7:0] host_wdata,
  input wire logic       host_ready,
  input wire logic [7:0] host_rdata,
  input wire logic       host_rvalid,
  input wire logic [6:0] address_counter,
  input wire logic       glyph_selected,
  input wire logic [5:0] display_shift,
  input wire logic       step_direction,
  input wire logic       shift_on_write,
  input wire logic       display_enable,
  input wire logic       cursor_enable,
  input wire logic       blink_enable,
  input wire logic       bus_width_sel,
  input wire logic       line_count_sel,
  input wire logic [1:0] luma_level,
  input wire logic       scan_blank
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_cmd_wr;
    host_valid && host_ready && host_write && !cmd_data_sel;
  endsequence
  sequence s_data_wr;
    host_valid && host_ready && host_write && cmd_data_sel;
  endsequence
  sequence s_fill_busy;
    !host_ready [*8];
  endsequence

  a_clear_resets_state:
    assert property (s_cmd_wr ##0 host_wdata == 8'h01 |=> address_counter == 7'h00
      && !glyph_selected && step_direction && display_shift == 6'h00 ##0 s_fill_busy)
    else $error("clear left wrong state");
  a_home_zero_all:
    assert property (s_cmd_wr ##0 host_wdata[7:1] == 7'h01 |=> address_counter == 7'h00
      && !glyph_selected && display_shift == 6'h00)
    else $error("home left wrong state");
  a_entry_mode_store:
    assert property (s_cmd_wr ##0 host_wdata[7:2] == 6'h01 |=>
      {step_direction, shift_on_write} == $past(host_wdata[1:0]))
    else $error("entry bits not stored");
  a_disp_ctrl_store:
    assert property (s_cmd_wr ##0 host_wdata[7:3] == 5'h01 |=>
      {display_enable, cursor_enable, blink_enable} == $past(host_wdata[2:0]))
    else $error("display control bits not stored");
  a_setup_store:
    assert property (s_cmd_wr ##0 host_wdata[7:5] == 3'h1 |=>
      {bus_width_sel, line_count_sel, luma_level} == {$past(host_wdata[4:3]),
      $past(host_wdata[1:0])})
    else $error("setup bits not stored");
  a_glyph_addr_load:
    assert property (s_cmd_wr ##0 host_wdata[7:6] == 2'h1 |=> glyph_selected
      && address_counter == {1'b0, $past(host_wdata[5:0])})
    else $error("glyph address not loaded");
  a_disp_addr_load:
    assert property (s_cmd_wr ##0 host_wdata[7] |=> !glyph_selected
      && address_counter == $past(host_wdata[6:0]))
    else $error("display address not loaded");
  a_status_read:
    assert property (host_valid && host_ready && !host_write && !cmd_data_sel |=>
      host_rvalid && host_rdata == {1'b0, $past(address_counter)})
    else $error("status read wrong");
  a_write_steps:
    assert property (s_data_wr ##0 !shift_on_write && !glyph_selected |=>
      address_counter == ($past(step_direction) ? $past(address_counter) + 7'h01
      : $past(address_counter) - 7'h01))
    else $error("counter did not step");
  a_write_shifts:
    assert property (s_data_wr ##0 shift_on_write && !glyph_selected |=>
      $stable(address_counter) && $changed(display_shift))
    else $error("write did not shift display");
  a_blank_follow:
    assert property (1'b1 |=> scan_blank == !$past(display_enable))
    else $error("blank does not follow enable");
endmodule

bind vfd_instruction_decoder vfd_decoder_chk vfd_decoder_chk_i (.*);

// File: testbench/vfd_host_model.sv
`timescale 1ns/10ps
module vfd_host_model
(
  input  wire logic       sys_clk,
  input  wire logic       host_ready,
  input  wire logic [7:0] host_rdata,
  input  wire logic       host_rvalid,
  output logic            host_valid,
  output logic            host_write,
  output logic            cmd_data_sel,
  output logic [7:0]      host_wdata
);
  int         gap = 0;
  logic [7:0] last_rd;
  logic       ok = 1'b1;

  initial
  begin
    host_valid   = 1'b0;
    host_write   = 1'b0;
    cmd_data_sel = 1'b0;
    host_wdata   = 8'h00;
  end

  // Request held until taken; data inverted after release so stale bytes never match
  task automatic xfer(input logic wr, input logic sel, input logic [7:0] d);
    int n;
    n = 0;
    repeat (gap) @(negedge sys_clk);
    @(negedge sys_clk);
    host_valid   = 1'b1;
    host_write   = wr;
    cmd_data_sel = sel;
    host_wdata   = d;
    // Ready is judged at the falling edge, clear of the edge that may change it
    while (host_ready !== 1'b1 && n < 400)
    begin
      n++;
      @(negedge sys_clk);
    end
    if (n == 400)
      ok = 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    last_rd = host_rdata;
    if (!wr && host_rvalid !== 1'b1)
      ok = 1'b0;
    host_valid = 1'b0;
    host_wdata = ~d;
  endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       host_valid, host_write, cmd_data_sel, host_ready, host_rvalid;
  logic [7:0] host_wdata, host_rdata, scan_code;
  logic [6:0] scan_addr = 7'h00;
  logic [6:0] address_counter;
  logic [2:0] scan_row = 3'h0;
  logic [4:0] grid_index;
  logic [5:0] display_shift;
  logic [1:0] luma_level;
  logic       scan_blank, scan_all_on, scan_cursor, seg_enable, glyph_selected;
  logic       step_direction, shift_on_write, display_enable, cursor_enable;
  logic       blink_enable, bus_width_sel, line_count_sel;
  int         err_total = 0;
  int         checks_done = 0;
  int         cyc = 0;

  always #10 sys_clk = ~sys_clk;

  vfd_instruction_decoder #(.LIT_CYCLES(40), .BLINK_CYCLES(16)) vfd_instruction_decoder_i (.*);
  vfd_host_model vfd_host_model_i (.*);

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(input logic [7:0] b);
    vfd_host_model_i.xfer(1'b1, 1'b0, b);
  endtask

  task automatic wr_data(input logic [7:0] b);
    vfd_host_model_i.xfer(1'b1, 1'b1, b);
  endtask

  task automatic rd(input logic sel, input string what, input logic [7:0] exp);
    vfd_host_model_i.xfer(1'b0, sel, 8'h00);
    chk(what, exp, vfd_host_model_i.last_rd);
  endtask

  task automatic t_reset_defaults();
    repeat (100) @(negedge sys_clk);
    chk("ready_fill", 8'h00, {7'h00, host_ready});
    repeat (35) @(negedge sys_clk);
    chk("ready_done", 8'h01, {7'h00, host_ready});
    chk("modes", 8'h86, {step_direction, shift_on_write, display_enable, cursor_enable,
      blink_enable, bus_width_sel, line_count_sel, glyph_selected});
    chk("luma_ctr", 8'h00, {luma_level, address_counter[5:0]});
    cmd(8'hA7);
    rd(1'b1, "fill", 8'h20);
  endtask

  task automatic t_modes();
    for (int i = 0; i < 16; i++)
    begin
      cmd(8'h08 | {5'h00, i[2:0]});
      chk("disp", {5'h00, i[2:0]}, {5'h00, display_enable, cursor_enable, blink_enable});
      cmd(8'h20 | {3'h0, i[3:2], 1'b0, i[1:0]});
      chk("setup", {4'h0, i[3:0]}, {4'h0, bus_width_sel, line_count_sel, luma_level});
      cmd(8'h04 | {6'h00, i[1:0]});
      chk("entry", {6'h00, i[1:0]}, {6'h00, step_direction, shift_on_write});
    end
  endtask

  task automatic t_ram();
    cmd(8'h06);
    cmd(8'hC3);
    wr_data(8'hA5);
    wr_data(8'h3C);
    rd(1'b0, "status", 8'h45);
    cmd(8'hC3);
    rd(1'b1, "rd0", 8'hA5);
    rd(1'b1, "rd1", 8'h3C);
    cmd(8'h7F);
    wr_data(8'h5A);
    chk("gwrap", 8'h00, {1'b0, address_counter});
    cmd(8'h7F);
    rd(1'b1, "glyph", 8'h5A);
    cmd(8'h04);
    cmd(8'h80);
    wr_data(8'h11);
    chk("dec", 8'h7F, {1'b0, address_counter});
  endtask

  task automatic t_shift_home();
    cmd(8'h06);
    cmd(8'h8A);
    cmd(8'h14);
    chk("cur_r", 8'h0B, {1'b0, address_counter});
    cmd(8'h10);
    chk("cur_l", 8'h0A, {1'b0, address_counter});
    cmd(8'h1C);
    chk("disp_r", 8'h8B, {display_shift[5:0] == 6'h27, address_counter});
    cmd(8'h18);
    chk("disp_l", 8'h0A, {display_shift != 6'h00, address_counter});
    cmd(8'h07);
    wr_data(8'h41);
    chk("wr_shift", 8'h81, {address_counter == 7'h0A, 1'b0, display_shift});
    scan_addr = 7'h09;
    repeat (2) @(negedge sys_clk);
    chk("scan_shift", 8'h41, scan_code);
    cmd(8'h03);
    chk("home", 8'h00, {glyph_selected, address_counter | {1'b0, display_shift}});
  endtask

  task automatic t_scan();
    int         n;
    logic [4:0] g;
    cmd(8'h0E);
    cmd(8'h85);
    scan_addr = 7'h05;
    scan_row  = 3'h7;
    repeat (2) @(negedge sys_clk);
    chk("cursor", 8'h01, {6'h00, scan_blank, scan_cursor});
    scan_row = 3'h6;
    repeat (2) @(negedge sys_clk);
    chk("no_cursor", 8'h00, {7'h00, scan_cursor});
    cmd(8'h3A);
    n = 0;
    g = grid_index;
    repeat (540) @(negedge sys_clk) n += seg_enable;
    chk("lit", 8'h14, n[7:0]);
    chk("grid", {3'h0, (g == 5'h13) ? 5'h00 : g + 5'h01}, {3'h0, grid_index});
    cmd(8'h0D);
    n = 0;
    repeat (64) @(negedge sys_clk) n += scan_all_on;
    chk("blink", 8'h20, n[7:0]);
  endtask

  task automatic t_clear();
    cmd(8'h05);
    cmd(8'hC3);
    wr_data(8'h77);
    cmd(8'h01);
    chk("clr", 8'h80, {step_direction, host_ready, display_shift | address_counter[5:0]});
    cmd(8'hC3);
    rd(1'b1, "clr_fill", 8'h20);
  endtask

  task automatic tally_and_finish();
    chk("host_handshake", 8'h01, {7'h00, vfd_host_model_i.ok});
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Whole run is about a thousand cycles; the ceiling only catches a hang
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      $display("CHECK FAILED cycle_limit expected %0d seen %0d", 0, cyc);
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    t_reset_defaults();
    t_modes();
    t_ram();
    t_shift_home();
    t_scan();
    t_clear();
    tally_and_finish();
  end
endmodule
